// *** tb/smbus_properties.sv ***
`timescale 1ns/1ps
module smbus_properties
    import charger_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_oe,
    input wire logic sda_dev_oe
);
    logic scl_q, sda_q, in_frame_q, start_w, stop_w;
    logic [7:0] byte_q;
    logic [4:0] bits_q;
    assign start_w = scl_q && scl && sda_q && !sda;
    assign stop_w = scl_q && scl && !sda_q && sda;
    always_ff @(posedge i_clk_sys) begin
        scl_q <= scl;
        sda_q <= sda;
    end
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n || stop_w) begin
            in_frame_q <= 1'b0;
        end else if (start_w) begin
            in_frame_q <= 1'b1;
        end
    end
    // counts clock rises of the first byte after each start, stops at the ack
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n || start_w) begin
            bits_q <= '0;
        end else if (!scl_q && scl && bits_q < 5'd9) begin
            bits_q <= bits_q + 5'd1;
            byte_q <= {byte_q[6:0], sda};
        end
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    sequence s_ninth;
        !scl_q && scl && bits_q == 5'd8;
    endsequence
    a_dev_rise_low: assert property ($rose(sda_dev_oe) |-> !scl) else $error("device grabbed sda with scl high");
    a_dev_fall_low: assert property ($fell(sda_dev_oe) |-> !scl) else $error("device freed sda with scl high");
    a_dev_stable_high: assert property (scl && $past(scl) |-> $stable(sda_dev_oe)) else $error("sda drive moved");
    a_dev_idle_quiet: assert property (!in_frame_q |-> !sda_dev_oe) else $error("device drove idle bus");
    a_addr_ack: assert property (s_ninth ##0 (byte_q == {DEV_ADDR, 1'b0}) |-> !sda) else $error("own address not acked");
    a_addr_nack: assert property (s_ninth ##0 (byte_q[7:1] != DEV_ADDR) |-> sda) else $error("foreign address acked");
    a_start_hold: assert property (start_w |-> scl [*3]) else $error("clock fell too soon after start");
    a_clk_in_frame: assert property ($fell(scl) |-> in_frame_q && scl_oe) else $error("clock outside frame");
endmodule : smbus_properties

// *** tb/tb.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb;
    import charger_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_reset_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [CMP_W-1:0] cmp = CMP_W'(1 << CMP_CELL_OK);
    logic [31:0] rdata, r, sts;
    logic sw, chg;
    logic [15:0] volt, curr, stat;
    int err_total = 0;
    int comparisons = 0;
    smbus_if bus ();
    charger_device i_charger_device (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .bus(bus),
        .i_adapter_above(cmp[CMP_ADAPTER]), .i_input_below_cell(cmp[CMP_PFAIL]), .i_thermistor_low(cmp[CMP_CELL_VOLTAGE_PIN]),
        .i_overtemp_latch(cmp[CMP_HOT]), .i_thermistor_underrange(cmp[CMP_UR]), .i_cell_below_low(cmp[CMP_CELL_LO]),
        .i_cell_above_high(cmp[CMP_CELL_OK]), .i_alarm_inhibit(cmp[CMP_ALARM]), .i_logic_supply_low(cmp[CMP_VDD_LOW]),
        .o_source_switch_driver(sw), .o_charge_enable(chg), .o_voltage_cmd(volt), .o_current_cmd(curr),
        .o_status_word(stat));
    smbus_host #(.QUARTER(4)) i_smbus_host (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .bus(bus),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata));
    smbus_properties i_smbus_properties (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .scl(bus.scl),
        .sda(bus.sda), .scl_oe(bus.scl_oe), .sda_dev_oe(bus.sda_dev_oe));
    always #4 i_clk_sys = ~i_clk_sys;
    task automatic settle(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask : settle
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_clk_sys);
        wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_clk_sys);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rreg
    // one word transfer; sts keeps the final host status, r the read word
    task automatic xfer(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d, input logic rw);
        int n;
        wreg(HR_TARGET, 32'({a, c}));
        wreg(HR_WDATA, 32'(d));
        wreg(HR_CTRL, 32'({rw, 1'b1}));
        n = 0;
        sts = 32'h0000_0001;
        while (sts[0] !== 1'b0 && n < 2000) begin
            rreg(HR_STATUS, sts);
            n++;
        end
        `CHK(sts[0], 1'b0)
        rreg(HR_RDATA, r);
    endtask : xfer
    task automatic stop_test();
        if (err_total == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        #400_000;
        err_total++;
        stop_test();
    end
    initial begin
        settle(12);
        i_reset_n <= 1'b1;
        settle(8);
        `CHK(volt, FLOAT_VOLT)
        `CHK(curr, WAKE_CURR)
        xfer(DEV_ADDR, CMD_CURRENT, 16'h0400, 1'b0);
        cmp[CMP_CELL_VOLTAGE_PIN] <= 1'b1;
        settle(8);
        `CHK(curr, CURR_POR)
        xfer(DEV_ADDR, CMD_SPEC, 16'h0000, 1'b1);
        `CHK(r[15:0], SPEC_WORD)
        `CHK(sts[1], 1'b0)
        xfer(7'h0A, CMD_SPEC, 16'h0000, 1'b1);
        `CHK(sts[1], 1'b1)
        rreg(8'h3C, r);
        `CHK(r, 32'h0000_0000)
        xfer(DEV_ADDR, CMD_CURRENT, 16'h0400, 1'b0);
        xfer(DEV_ADDR, CMD_VOLTAGE, 16'h3010, 1'b0);
        `CHK(curr, 16'h0400)
        `CHK(volt, 16'h3010)
        cmp[CMP_CELL_LO] <= 1'b1;
        cmp[CMP_CELL_OK] <= 1'b0;
        settle(8);
        `CHK(curr, WAKE_CURR)
        cmp[CMP_CELL_LO] <= 1'b0;
        settle(8);
        `CHK(curr, WAKE_CURR)
        cmp[CMP_CELL_OK] <= 1'b1;
        cmp[CMP_ADAPTER] <= 1'b1;
        settle(8);
        `CHK(curr, 16'h0400)
        xfer(DEV_ADDR, CMD_STATUS, 16'h0000, 1'b1);
        `CHK(r[15:0], 16'hC000)
        `CHK(chg, 1'b1)
        cmp[CMP_PFAIL] <= 1'b1;
        xfer(DEV_ADDR, CMD_STATUS, 16'h0000, 1'b1);
        `CHK(r[15:0], 16'hE000)
        `CHK(sw, 1'b0)
        cmp[CMP_PFAIL] <= 1'b0;
        cmp[CMP_ALARM] <= 1'b1;
        settle(8);
        cmp[CMP_ALARM] <= 1'b0;
        settle(8);
        `CHK(stat[ST_ALARM], 1'b1)
        xfer(DEV_ADDR, CMD_CURRENT, 16'h0200, 1'b0);
        `CHK(stat[ST_ALARM], 1'b0)
        cmp[CMP_ALARM] <= 1'b1;
        settle(8);
        cmp[CMP_ALARM] <= 1'b0;
        xfer(DEV_ADDR, CMD_MODE, MODE_RESET | 16'h0004, 1'b0);
        `CHK(volt, VOLT_POR)
        `CHK(curr, CURR_POR)
        `CHK(stat[ST_ALARM], 1'b0)
        xfer(DEV_ADDR, CMD_MODE, 16'h0001, 1'b0);
        `CHK(stat[ST_INHIB], 1'b1)
        `CHK(chg, 1'b0)
        xfer(DEV_ADDR, CMD_MODE, 16'h0000, 1'b0);
        cmp[CMP_HOT] <= 1'b1;
        settle(8);
        `CHK(stat[ST_HOT], 1'b1)
        `CHK(chg, 1'b1)
        cmp[CMP_CELL_VOLTAGE_PIN] <= 1'b0;
        settle(8);
        `CHK(stat[ST_HOT], 1'b0)
        `CHK(curr, WAKE_CURR)
        cmp[CMP_CELL_VOLTAGE_PIN] <= 1'b1;
        settle(8);
        `CHK(chg, 1'b0)
        `CHK(curr, CURR_POR)
        xfer(DEV_ADDR, CMD_CURRENT, 16'h0300, 1'b0);
        `CHK(curr, 16'h0300)
        cmp[CMP_VDD_LOW] <= 1'b1;
        settle(8);
        `CHK(sw, 1'b0)
        `CHK(volt, FLOAT_VOLT)
        cmp[CMP_VDD_LOW] <= 1'b0;
        settle(8);
        `CHK(curr, CURR_POR)
        stop_test();
    end
endmodule : tb

// *** verilog/charger_device.sv ***
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module charger_device (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // bus pins
    smbus_if.device bus,
    // comparators
    input wire logic i_adapter_above,
    input wire logic i_input_below_cell,
    input wire logic i_thermistor_low,
    input wire logic i_overtemp_latch,
    input wire logic i_thermistor_underrange,
    input wire logic i_cell_below_low,
    input wire logic i_cell_above_high,
    input wire logic i_alarm_inhibit,
    input wire logic i_logic_supply_low,
    // charge controls and status word
    output logic o_source_switch_driver,
    output logic o_charge_enable,
    output logic [15:0] o_voltage_cmd,
    output logic [15:0] o_current_cmd,
    output logic [15:0] o_status_word
);
    import charger_pkg::*;

    logic [CMP_W-1:0] cmp_raw;
    logic [CMP_W-1:0] cmp_meta_q;
    logic [CMP_W-1:0] cmp_q;
    logic scl_s1_q, scl_s2_q, scl_s3_q;
    logic sda_s1_q, sda_s2_q, sda_s3_q;
    logic rst;
    logic scl_rise, scl_fall, start_seen, stop_seen;
    dev_state_t st_q;
    logic [3:0] cnt_q;
    logic [7:0] shift_q;
    logic [7:0] cmd_q;
    logic [7:0] lo_q;
    logic [7:0] tx_q;
    logic [7:0] hi_byte;
    logic cmd_ok_q;
    logic drive_q;
    logic commit_q;
    logic [15:0] wdata_q;
    logic [15:0] mode_q;
    logic [15:0] volt_q;
    logic [15:0] curr_q;
    logic hot_q, alarm_q, uv_q;
    logic cell_voltage_pin, por_wr, setp_wr;
    logic [15:0] status;
    logic [15:0] rd_word;

    assign cmp_raw = {i_logic_supply_low, i_alarm_inhibit, i_cell_above_high,
                      i_cell_below_low, i_thermistor_underrange, i_overtemp_latch,
                      i_thermistor_low, i_input_below_cell, i_adapter_above};

    // two-flop synchronisers for every outside level
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            cmp_meta_q <= '0;
            cmp_q <= '0;
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
        end else begin
            cmp_meta_q <= cmp_raw;
            cmp_q <= cmp_meta_q;
            scl_s1_q <= bus.scl;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= bus.sda;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
        end
    end

    assign rst = !i_reset_n || cmp_q[CMP_VDD_LOW];
    assign cell_voltage_pin = cmp_q[CMP_CELL_VOLTAGE_PIN];
    assign scl_rise = scl_s2_q && !scl_s3_q;
    assign scl_fall = !scl_s2_q && scl_s3_q;
    assign start_seen = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
    assign stop_seen = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;
    assign por_wr = commit_q && cmd_q == CMD_MODE && wdata_q[MODE_POR];
    assign setp_wr = commit_q && (cmd_q == CMD_CURRENT || cmd_q == CMD_VOLTAGE);

    always_comb begin
        status = '0;
        status[ST_AC] = cmp_q[CMP_ADAPTER];
        status[ST_CELL_VOLTAGE_PIN] = cell_voltage_pin;
        status[ST_PFAIL] = cmp_q[CMP_PFAIL];
        status[ST_ALARM] = alarm_q;
        status[ST_HOT] = hot_q;
        status[ST_UR] = cmp_q[CMP_UR];
        status[ST_INHIB] = mode_q[MODE_INHIBIT];
    end

    always_comb begin
        unique case (cmd_q)
            CMD_SPEC: rd_word = SPEC_WORD;
            CMD_STATUS: rd_word = status;
            default: rd_word = NO_WORD;
        endcase
    end

    assign hi_byte = rd_word[15:8];

    // slave byte engine: sample on scl rise, change sda on scl fall
    always_ff @(posedge i_clk_sys) begin
        if (rst) begin
            st_q <= DS_IDLE;
            cnt_q <= '0;
            shift_q <= '0;
            cmd_q <= '0;
            lo_q <= '0;
            tx_q <= '0;
            cmd_ok_q <= 1'b0;
            drive_q <= 1'b0;
            commit_q <= 1'b0;
            wdata_q <= '0;
        end else begin
            commit_q <= 1'b0;
            if (start_seen) begin
                st_q <= DS_ADDR;
                cnt_q <= '0;
                drive_q <= 1'b0;
            end else if (stop_seen) begin
                st_q <= DS_IDLE;
                cmd_ok_q <= 1'b0;
                drive_q <= 1'b0;
            end else if (st_q != DS_IDLE && scl_rise) begin
                if (cnt_q < ACK_BIT) begin
                    shift_q <= {shift_q[6:0], sda_s2_q};
                end
                // master nack ends the read
                if (cnt_q == ACK_BIT && (st_q == DS_RLO || st_q == DS_RHI) && sda_s2_q) begin
                    st_q <= DS_DONE;
                end
                cnt_q <= cnt_q + 4'h1;
            end else if (st_q != DS_IDLE && scl_fall) begin
                if (cnt_q == ACK_BIT) begin
                    unique case (st_q)
                        DS_ADDR: begin
                            if (shift_q[7:1] == DEV_ADDR && (!shift_q[0] || cmd_ok_q)) begin
                                drive_q <= 1'b1;
                            end else begin
                                st_q <= DS_IDLE;
                            end
                        end
                        DS_CMD: begin
                            cmd_q <= shift_q;
                            cmd_ok_q <= 1'b1;
                            drive_q <= 1'b1;
                        end
                        DS_WLO: begin
                            lo_q <= shift_q;
                            drive_q <= 1'b1;
                        end
                        DS_WHI: begin
                            wdata_q <= {shift_q, lo_q};
                            commit_q <= 1'b1;
                            drive_q <= 1'b1;
                        end
                        default: drive_q <= 1'b0;
                    endcase
                end else if (cnt_q == END_BIT) begin
                    cnt_q <= '0;
                    drive_q <= 1'b0;
                    unique case (st_q)
                        DS_ADDR: begin
                            if (shift_q[0]) begin
                                st_q <= DS_RLO;
                                tx_q <= rd_word[7:0];
                                drive_q <= !rd_word[7];
                            end else begin
                                st_q <= DS_CMD;
                            end
                        end
                        DS_CMD: st_q <= DS_WLO;
                        DS_WLO: st_q <= DS_WHI;
                        DS_RLO: begin
                            st_q <= DS_RHI;
                            tx_q <= hi_byte;
                            drive_q <= !hi_byte[7];
                        end
                        default: st_q <= DS_DONE;
                    endcase
                end else if (st_q == DS_RLO || st_q == DS_RHI) begin
                    drive_q <= !tx_q[3'(TX_MSB - cnt_q)];
                end
            end
        end
    end

    // command registers
    always_ff @(posedge i_clk_sys) begin
        if (rst || !cell_voltage_pin) begin
            mode_q <= MODE_RESET;
            volt_q <= VOLT_POR;
            curr_q <= CURR_POR;
        end else if (commit_q) begin
            unique case (cmd_q)
                CMD_MODE: begin
                    mode_q <= wdata_q & MODE_KEEP;
                    if (wdata_q[MODE_POR]) begin
                        volt_q <= VOLT_POR;
                        curr_q <= CURR_POR;
                    end
                end
                CMD_CURRENT: curr_q <= wdata_q;
                CMD_VOLTAGE: volt_q <= wdata_q;
                default: ;
            endcase
        end
    end

    // latched status flags, a set beats a same-cycle clear
    always_ff @(posedge i_clk_sys) begin
        if (rst) begin
            hot_q <= 1'b0;
        end else if (cmp_q[CMP_HOT] && cell_voltage_pin) begin
            hot_q <= 1'b1;
        end else if (!cell_voltage_pin || por_wr) begin
            hot_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (rst) begin
            alarm_q <= 1'b0;
        end else if (cmp_q[CMP_ALARM] && cell_voltage_pin) begin
            alarm_q <= 1'b1;
        end else if (!cell_voltage_pin || por_wr || setp_wr) begin
            alarm_q <= 1'b0;
        end
    end

    // cell undervoltage with hysteresis
    always_ff @(posedge i_clk_sys) begin
        if (rst) begin
            uv_q <= 1'b0;
        end else if (cmp_q[CMP_CELL_LO]) begin
            uv_q <= 1'b1;
        end else if (cmp_q[CMP_CELL_OK]) begin
            uv_q <= 1'b0;
        end
    end

    // registered outputs
    always_ff @(posedge i_clk_sys) begin
        if (rst) begin
            o_source_switch_driver <= 1'b0;
            o_charge_enable <= 1'b0;
            o_voltage_cmd <= FLOAT_VOLT;
            o_current_cmd <= WAKE_CURR;
            o_status_word <= '0;
        end else begin
            o_source_switch_driver <= !cmp_q[CMP_PFAIL];
            o_charge_enable <= cmp_q[CMP_ADAPTER] && !cmp_q[CMP_PFAIL]
                && !mode_q[MODE_INHIBIT] && !(mode_q[MODE_OVERTEMP_HALT_ENABLE] && hot_q);
            o_voltage_cmd <= cell_voltage_pin ? volt_q : FLOAT_VOLT;
            if (!cell_voltage_pin) begin
                o_current_cmd <= WAKE_CURR;
            end else if (uv_q && curr_q > WAKE_CURR) begin
                o_current_cmd <= WAKE_CURR;
            end else begin
                o_current_cmd <= curr_q;
            end
            o_status_word <= status;
        end
    end

    assign bus.sda_dev_out = 1'b0;
    assign bus.sda_dev_oe = drive_q;
endmodule : charger_device

// *** verilog/charger_pkg.sv ***
// Function
// - adapter above threshold sets status bit 15
// - input below cell: power fail, switch off
// - thermistor low means battery present, bit 14
// - no battery holds command registers at reset
// - no battery: float 18.32V at 128mA
// - cell undervoltage caps current, hysteresis release
// - logic supply low: ignore bus, reset
// - device is slave, read/write word only
// - master frames transfers with start, stop
// - device answers address 0x09 only
// - command 0x11 reads constant 0x09
// - spec word: version, no selector, zeros
// - mode written by write-word command 0x12
// - battery removal restores overtemp halt bit
// - host clears overtemp halt after insertion
// - status read by read-word command 0x13
// - battery loss or reset clears latches
// - setpoint writes clear alarm-inhibited latch
// - data bit 0 is word bit D0
// - mode reset bit loads setpoint reset values
package charger_pkg;
    localparam logic [6:0] DEV_ADDR = 7'h09;
    localparam logic [7:0] CMD_SPEC = 8'h11;
    localparam logic [7:0] CMD_MODE = 8'h12;
    localparam logic [7:0] CMD_STATUS = 8'h13;
    localparam logic [7:0] CMD_CURRENT = 8'h14;
    localparam logic [7:0] CMD_VOLTAGE = 8'h15;
    localparam logic [15:0] SPEC_WORD = 16'h0009;
    localparam logic [15:0] NO_WORD = 16'hFFFF;
    localparam logic [15:0] MODE_RESET = 16'h0400;
    localparam logic [15:0] MODE_KEEP = 16'h0471;
    localparam int MODE_INHIBIT = 0;
    localparam int MODE_POR = 2;
    localparam int MODE_OVERTEMP_HALT_ENABLE = 10;
    localparam logic [15:0] VOLT_POR = 16'hFFFF;
    localparam logic [15:0] CURR_POR = 16'h00C0;
    localparam logic [15:0] FLOAT_VOLT = 16'h4790;
    localparam logic [15:0] WAKE_CURR = 16'h0080;
    localparam int ST_AC = 15;
    localparam int ST_CELL_VOLTAGE_PIN = 14;
    localparam int ST_PFAIL = 13;
    localparam int ST_ALARM = 12;
    localparam int ST_HOT = 11;
    localparam int ST_UR = 10;
    localparam int ST_INHIB = 0;
    localparam int CMP_ADAPTER = 0;
    localparam int CMP_PFAIL = 1;
    localparam int CMP_CELL_VOLTAGE_PIN = 2;
    localparam int CMP_HOT = 3;
    localparam int CMP_UR = 4;
    localparam int CMP_CELL_LO = 5;
    localparam int CMP_CELL_OK = 6;
    localparam int CMP_ALARM = 7;
    localparam int CMP_VDD_LOW = 8;
    localparam int CMP_W = 9;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [3:0] END_BIT = 4'h9;
    localparam logic [3:0] TX_MSB = 4'h7;
    localparam logic [7:0] HR_CTRL = 8'h00;
    localparam logic [7:0] HR_TARGET = 8'h04;
    localparam logic [7:0] HR_WDATA = 8'h08;
    localparam logic [7:0] HR_RDATA = 8'h0C;
    localparam logic [7:0] HR_STATUS = 8'h10;
    localparam int CTRL_GO = 0;
    localparam int CTRL_READ = 1;
    localparam int SYS_CLK_MHZ = 125;
    localparam int SMB_CLK_KHZ = 100;
    localparam int QUARTER_CYCLES = SYS_CLK_MHZ * 1000 / (4 * SMB_CLK_KHZ);
    typedef enum logic [2:0] {
        DS_IDLE = 3'b000,
        DS_ADDR = 3'b001,
        DS_CMD = 3'b010,
        DS_WLO = 3'b011,
        DS_WHI = 3'b100,
        DS_RLO = 3'b101,
        DS_RHI = 3'b110,
        DS_DONE = 3'b111
    } dev_state_t;
    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_START = 3'b001,
        HS_BYTE = 3'b010,
        HS_RSTART = 3'b011,
        HS_STOP = 3'b100
    } host_state_t;
endpackage : charger_pkg

// *** verilog/smbus_host.sv ***
`timescale 1ns/1ps
module smbus_host #(
    parameter int QUARTER = charger_pkg::QUARTER_CYCLES
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // bus pins
    smbus_if.host bus,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata
);
    import charger_pkg::*;

    host_state_t st_q;
    logic [15:0] tick_q;
    logic tick;
    logic [1:0] ph_q;
    logic [3:0] bit_q;
    logic [2:0] byte_q;
    logic [14:0] target_q;
    logic [15:0] wdata_q;
    logic [15:0] rdata_q;
    logic [7:0] shift_q;
    logic read_q, busy_q, nack_q;
    logic scl_drv_q, sda_drv_q;
    logic sda_m_q, sda_q;
    logic is_rx, last;
    logic [7:0] txb;

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            sda_m_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            sda_m_q <= bus.sda;
            sda_q <= sda_m_q;
        end
    end

    assign tick = st_q != HS_IDLE && tick_q == 16'(QUARTER - 1);
    assign is_rx = read_q && byte_q > 3'h2;
    assign last = byte_q == (read_q ? 3'h4 : 3'h3);

    always_comb begin
        unique case (byte_q)
            3'h0: txb = {target_q[14:8], 1'b0};
            3'h1: txb = target_q[7:0];
            3'h2: txb = read_q ? {target_q[14:8], 1'b1} : wdata_q[7:0];
            default: txb = wdata_q[15:8];
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        // the quarter counter runs only while a transfer is under way and restarts after each tick
        if (!i_reset_n || tick || st_q == HS_IDLE) begin
            tick_q <= '0;
        end else begin
            tick_q <= tick_q + 16'h0001;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            target_q <= '0;
            wdata_q <= '0;
        end else if (i_wr && i_addr == HR_TARGET) begin
            target_q <= i_wdata[14:0];
        end else if (i_wr && i_addr == HR_WDATA) begin
            wdata_q <= i_wdata[15:0];
        end
    end

    // bit sequencer, four quarter phases per scl period
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            st_q <= HS_IDLE;
            ph_q <= '0;
            bit_q <= '0;
            byte_q <= '0;
            read_q <= 1'b0;
            busy_q <= 1'b0;
            nack_q <= 1'b0;
            scl_drv_q <= 1'b0;
            sda_drv_q <= 1'b0;
            shift_q <= '0;
            rdata_q <= '0;
        end else if (st_q == HS_IDLE) begin
            if (i_wr && i_addr == HR_CTRL && i_wdata[CTRL_GO]) begin
                st_q <= HS_START;
                read_q <= i_wdata[CTRL_READ];
                busy_q <= 1'b1;
                nack_q <= 1'b0;
                ph_q <= '0;
                bit_q <= '0;
                byte_q <= '0;
            end
        end else if (tick) begin
            ph_q <= ph_q + 2'h1;
            unique case (st_q)
                HS_START: begin
                    if (ph_q == 2'h0) begin
                        sda_drv_q <= 1'b1;
                    end else begin
                        scl_drv_q <= 1'b1;
                        st_q <= HS_BYTE;
                        ph_q <= '0;
                    end
                end
                HS_RSTART: begin
                    sda_drv_q <= ph_q[1];
                    scl_drv_q <= ph_q == 2'h3;
                    if (ph_q == 2'h3) begin
                        st_q <= HS_BYTE;
                    end
                end
                HS_STOP: begin
                    if (ph_q == 2'h0) begin
                        sda_drv_q <= 1'b1;
                    end else if (ph_q == 2'h1) begin
                        scl_drv_q <= 1'b0;
                    end else if (ph_q == 2'h2) begin
                        sda_drv_q <= 1'b0;
                    end else begin
                        st_q <= HS_IDLE;
                        busy_q <= 1'b0;
                    end
                end
                default: begin
                    if (ph_q == 2'h0) begin
                        if (bit_q < ACK_BIT) begin
                            sda_drv_q <= !is_rx && !txb[3'(TX_MSB - bit_q)];
                        end else begin
                            sda_drv_q <= is_rx && !last;
                        end
                    end else if (ph_q == 2'h1) begin
                        scl_drv_q <= 1'b0;
                    end else if (ph_q == 2'h2) begin
                        if (bit_q < ACK_BIT) begin
                            shift_q <= {shift_q[6:0], sda_q};
                        end else if (!is_rx && sda_q) begin
                            nack_q <= 1'b1;
                        end
                    end else begin
                        scl_drv_q <= 1'b1;
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == ACK_BIT) begin
                            bit_q <= '0;
                            byte_q <= byte_q + 3'h1;
                            if (is_rx && last) begin
                                rdata_q[15:8] <= shift_q;
                            end else if (is_rx) begin
                                rdata_q[7:0] <= shift_q;
                            end
                            if (nack_q || last) begin
                                st_q <= HS_STOP;
                            end else if (read_q && byte_q == 3'h1) begin
                                st_q <= HS_RSTART;
                            end
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_rdata <= '0;
        end else if (i_rd && i_addr == HR_RDATA) begin
            o_rdata <= {16'h0000, rdata_q};
        end else if (i_rd && i_addr == HR_STATUS) begin
            o_rdata <= {30'h000_0000, nack_q, busy_q};
        end else begin
            o_rdata <= '0;
        end
    end

    assign bus.scl_out = 1'b0;
    assign bus.scl_oe = scl_drv_q;
    assign bus.sda_host_out = 1'b0;
    assign bus.sda_host_oe = sda_drv_q;
endmodule : smbus_host

// *** verilog/smbus_if.sv ***
`timescale 1ns/1ps
interface smbus_if;
    logic scl_out;
    logic scl_oe;
    logic sda_dev_out;
    logic sda_dev_oe;
    logic sda_host_out;
    logic sda_host_oe;
    logic scl;
    logic sda;
    // open-drain wires with pullups
    assign scl = !(scl_oe && !scl_out);
    assign sda = !((sda_dev_oe && !sda_dev_out) || (sda_host_oe && !sda_host_out));
    modport device (input scl, input sda, output sda_dev_out, output sda_dev_oe);
    modport host (input scl, input sda, output scl_out, output scl_oe, output sda_host_out, output sda_host_oe);
endinterface : smbus_if
